/* File: hw/sec_map.svh */
// Constants for the two-wire EEPROM client write path: field positions,
// sizes and timing figures.
// Assumes a 250 MHz system clock; included by sec_pkg.sv and sec_client.sv.
//
// What this block does
// - First byte after Start is the control byte; its type code must match.
// - Three chip-select bits must equal the three address-select inputs to respond.
// - Control byte bit zero: one means read, zero means write.
// - Two address bytes follow a write, high first; top three bits ignored.
// - Matching control byte is acknowledged on the ninth clock, then read or write.
// - Byte write: high address, low address, data, each acknowledged; address loaded.
// - Stop after write data starts the timed write; no acknowledge until it ends.
// - Write-protect high: bytes acknowledged, no write cycle, ready at once.
// - After a byte write the pointer holds the following location within the same page.
// - Short writes still rewrite the whole page, other bytes refreshed.
// - Up to 31 more data bytes are buffered and committed only after Stop or a repeated Start.
// - Each data byte increments only the low five pointer bits.
// - More than 32 data bytes wrap within the page, overwriting earlier ones.
// - Write-protect high blocks writes to the whole array.
// - Write-protect is sampled once at the Stop or Start that launches the write; later changes have no effect.
// - After the write cycle a matching control byte is acknowledged again.
// - The pointer never leaves this device's own address range.
// - Data falling while clock high is a Start; every command begins with one.
// - Data rising while clock high is a Stop; every operation ends with one.
// - Only the last 32 bytes are kept, oldest replaced first.
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

// Control byte fields
`define SEC_TYPE_HI      7
`define SEC_TYPE_LO      4
`define SEC_CSEL_HI      3
`define SEC_CSEL_LO      1
`define SEC_RW_BIT       0

// Array and page geometry
`define SEC_ADDR_W       13
`define SEC_ADDR_HI_BITS 5
`define SEC_PAGE_BYTES   32
`define SEC_PAGE_IDX_W   5
`define SEC_PAGE_NUM_W   8
`define SEC_BIT_LAST     4'h7
`define SEC_BIT_ACK      4'h8

// Write cycle timing
`define SEC_WRITE_TIME_US 5000
`define SEC_CLK_MHZ       250
`define SEC_WRITE_CYCLES  (`SEC_WRITE_TIME_US * `SEC_CLK_MHZ)
`define SEC_WCNT_W        21

`endif

/* File: hw/sec_pkg.sv */
// Types for the two-wire EEPROM client write path.
// Assumes sec_map.svh is on the include path.
`include "sec_map.svh"

package sec_pkg;

  // Protocol states, one-hot
  typedef enum logic [6:0] {
    SEC_IDLE    = 7'b0000001,
    SEC_CTRL    = 7'b0000010,
    SEC_ADDR_HI = 7'b0000100,
    SEC_ADDR_LO = 7'b0001000,
    SEC_DATA    = 7'b0010000,
    SEC_READ    = 7'b0100000,
    SEC_IGNORE  = 7'b1000000
  } sec_state_type;

endpackage : sec_pkg

/* File: hw/sec_link.sv */
// Link-side bit capture, clocked by the bus clock itself.
// Assumes the bus clock only runs during frames; each rising edge samples
// the data line and toggles an event flag for the system domain.
`timescale 1ns/1ns
`default_nettype none

module sec_link (
  // Link clock and reset
  input  wire logic scl_clk,
  input  wire logic resetn,
  // Data line as seen at the pin
  input  wire logic sda_in,
  // Captured bit and its event toggle
  output logic      bit_val,
  output logic      bit_tgl
);

  // Sample on each rising clock; value holds a full bus period for the crossing
  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      bit_val <= 1'b0;
      bit_tgl <= 1'b0;
    end else begin
      bit_val <= sda_in;
      bit_tgl <= ~bit_tgl;
    end
  end

endmodule : sec_link
`default_nettype wire

/* File: hw/sec_client.sv */
// Two-wire EEPROM client front end: control byte decode, address load,
// page buffer, write-protect and self-timed busy period.
// Assumes the bus clock arrives both as a link clock and as a pin level, and
// that the array outside merges the page using the byte mask.
`timescale 1ns/1ns
`default_nettype none
`include "sec_map.svh"

module sec_client
  import sec_pkg::*;
#(
  parameter logic [3:0]  TYPE_CODE    = 4'h6,  // Arbitrary value
  parameter int unsigned WRITE_CYCLES = `SEC_WRITE_CYCLES,
  parameter int unsigned PAGE_BYTES   = `SEC_PAGE_BYTES
) (
  // System clock, reset, enable
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  // Bus pins
  input  wire logic                          scl_clk,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  // Straps
  input  wire logic                          chip_sel_bit_low,
  input  wire logic                          chip_sel_bit_mid,
  input  wire logic                          chip_sel_bit_high,
  input  wire logic                          wp,
  // Status
  output logic                               busy,
  output logic [`SEC_ADDR_W-1:0]             addr_ptr,
  // Page commit to the array
  output logic                               commit,
  output logic [`SEC_PAGE_NUM_W-1:0]         commit_page,
  output logic [PAGE_BYTES*8-1:0]            commit_data,
  output logic [PAGE_BYTES-1:0]              commit_mask
);

  localparam int PIN_N = 6;

  // Pin synchronisers: two flops, nothing reads the first
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_m;
  logic [PIN_N-1:0] pin_s;
  assign pin_raw = {scl_in, sda_in, wp, chip_sel_bit_high, chip_sel_bit_mid,
                    chip_sel_bit_low};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_m[gi] <= 1'b1;
          pin_s[gi] <= 1'b1;
        end else if (ce) begin
          pin_m[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_m[gi];
        end
      end
    end
  endgenerate

  wire       scl_s  = pin_s[5];
  wire       sda_s  = pin_s[4];
  wire       wp_s   = pin_s[3];
  wire [2:0] csel_s = pin_s[2:0];

  // Link domain capture
  logic bit_val;
  logic bit_tgl;

  sec_link u_link (
    .scl_clk (scl_clk),
    .resetn  (resetn),
    .sda_in  (sda_in),
    .bit_val (bit_val),
    .bit_tgl (bit_tgl)
  );

  // Toggle crossing; captured bit is stable while the toggle settles
  logic tgl_m;
  logic tgl_s;
  logic tgl_d;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      tgl_d <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      tgl_m <= bit_tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus conditions
  wire start_ev = ce & scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = ce & scl_s & scl_d & ~sda_d & sda_s;
  wire scl_fall = ce & scl_d & ~scl_s;
  wire bit_ev   = ce & (tgl_s ^ tgl_d) & ~start_ev & ~stop_ev;

  // Byte assembly
  sec_state_type state;
  logic [3:0]    bit_cnt;
  logic [7:0]    shreg;
  logic          ack_pend;
  logic          ack_seen;
  logic          data_seen;

  wire [7:0] rx_byte   = {shreg[6:0], bit_val};
  wire       byte_ev   = bit_ev & (bit_cnt == `SEC_BIT_LAST);
  wire       ack_clk   = bit_ev & (bit_cnt == `SEC_BIT_ACK);

  // Control byte decode
  wire type_ok  = rx_byte[`SEC_TYPE_HI:`SEC_TYPE_LO] == TYPE_CODE;
  wire csel_ok  = rx_byte[`SEC_CSEL_HI:`SEC_CSEL_LO] == csel_s;
  wire ctrl_hit = type_ok & csel_ok & ~busy;
  wire is_read  = rx_byte[`SEC_RW_BIT];

  wire take_ctrl = byte_ev & (state == SEC_CTRL);
  wire take_ahi  = byte_ev & (state == SEC_ADDR_HI);
  wire take_alo  = byte_ev & (state == SEC_ADDR_LO);
  wire take_data = byte_ev & (state == SEC_DATA);
  wire byte_ack  = (take_ctrl & ctrl_hit) | take_ahi | take_alo | take_data;

  // A write launches only after a full data byte is received, even if its acknowledge clock never comes
  wire launch    = (start_ev | stop_ev) & data_seen;
  wire launch_wr = launch & ~wp_s;

  // Next state
  sec_state_type next_state;
  always_comb begin
    next_state = state;
    if (start_ev) begin
      next_state = SEC_CTRL;
    end else if (stop_ev) begin
      next_state = SEC_IDLE;
    end else if (byte_ev) begin
      case (state)
        SEC_CTRL: begin
          if (!ctrl_hit) begin
            next_state = SEC_IGNORE;
          end else if (is_read) begin
            next_state = SEC_READ;
          end else begin
            next_state = SEC_ADDR_HI;
          end
        end
        SEC_ADDR_HI: next_state = SEC_ADDR_LO;
        SEC_ADDR_LO: next_state = SEC_DATA;
        SEC_DATA:    next_state = SEC_DATA;
        SEC_READ:    next_state = SEC_READ;
        SEC_IGNORE:  next_state = SEC_IGNORE;
        default:     next_state = SEC_IDLE;
      endcase
    end
  end

  // State and bit counter; Start or Stop aborts any partial byte
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state   <= SEC_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end else if (ce) begin
      state <= next_state;
      if (start_ev || stop_ev) begin
        bit_cnt <= 4'h0;
      end else if (ack_clk) begin
        bit_cnt <= 4'h0;
      end else if (bit_ev) begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg   <= rx_byte;
      end
    end
  end

  // Acknowledge driver: pull low from the fall after bit 8 to the fall after bit 9
  assign sda_out = 1'b0;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_pend <= 1'b0;
      ack_seen <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (ce) begin
      if (start_ev || stop_ev) begin
        ack_pend <= 1'b0;
        ack_seen <= 1'b0;
        sda_oe   <= 1'b0;
      end else begin
        if (byte_ev) begin
          ack_pend <= byte_ack;
        end
        if (ack_clk) begin
          ack_seen <= 1'b1;
        end
        if (scl_fall && ack_pend) begin
          sda_oe   <= 1'b1;
          ack_pend <= 1'b0;
        end else if (scl_fall && ack_seen) begin
          sda_oe   <= 1'b0;
          ack_seen <= 1'b0;
        end
      end
    end
  end

  // Address pointer: only 13 bits exist, so it cannot reach another device
  wire [`SEC_PAGE_IDX_W-1:0] byte_idx = addr_ptr[`SEC_PAGE_IDX_W-1:0];
  wire [`SEC_PAGE_IDX_W-1:0] next_idx = byte_idx + 5'h01;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_ptr <= 13'h0000;
    end else if (ce) begin
      if (take_ahi) begin
        addr_ptr[12:8] <= rx_byte[`SEC_ADDR_HI_BITS-1:0];
      end else if (take_alo) begin
        addr_ptr[7:0] <= rx_byte;
      end else if (take_data) begin
        addr_ptr[`SEC_PAGE_IDX_W-1:0] <= next_idx;
      end
    end
  end

  // Page buffer: index wraps, so only the last 32 bytes survive
  logic [7:0] page_buf [PAGE_BYTES];
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      page_buf <= '{default: 8'h00};
    end else if (ce && take_data) begin
      page_buf[byte_idx] <= rx_byte;
    end
  end

  // Flatten the buffer for the array; one slice per byte lane
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_buf
      assign commit_data[gi*8 +: 8] = page_buf[gi];
    end
  endgenerate

  // Byte mask; cleared bytes are refreshed from the array
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      commit_mask <= '0;
      data_seen   <= 1'b0;
    end else if (ce) begin
      if (take_alo) begin
        commit_mask <= '0;
        data_seen   <= 1'b0;
      end else if (take_data) begin
        commit_mask[byte_idx] <= 1'b1;
        data_seen             <= 1'b1;
      end else if (launch) begin
        data_seen <= 1'b0;
      end
    end
  end

  // Self-timed write cycle; busy stays silent on the bus until expiry
  logic [`SEC_WCNT_W-1:0] wcnt;
  localparam logic [`SEC_WCNT_W-1:0] WCNT_LAST = `SEC_WCNT_W'(WRITE_CYCLES - 1);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy        <= 1'b0;
      wcnt        <= '0;
      commit      <= 1'b0;
      commit_page <= 8'h00;
    end else if (ce) begin
      commit <= launch_wr;
      if (launch_wr) begin
        busy        <= 1'b1;
        wcnt        <= '0;
        commit_page <= addr_ptr[12:5];
      end else if (busy) begin
        if (wcnt == WCNT_LAST) begin
          busy <= 1'b0;
        end else begin
          wcnt <= wcnt + 21'h000001;
        end
      end
    end
  end

  // Checks; every antecedent is a design event reached by bus traffic, and wp_block_a also needs the wp strap high
  ack_not_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(sda_oe) |-> !busy) else $error("acknowledge driven while busy");
  type_miss_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (take_ctrl && !type_ok) |=> (state == SEC_IGNORE && !ack_pend))
    else $error("wrong type code not ignored");
  csel_miss_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (take_ctrl && !csel_ok) |=> state == SEC_IGNORE)
    else $error("chip select mismatch accepted");
  read_select_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (take_ctrl && ctrl_hit && is_read) |=> (state == SEC_READ && ack_pend))
    else $error("read control byte mishandled");
  addr_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_ahi |=> addr_ptr[12:8] == $past(rx_byte[4:0]))
    else $error("high address not loaded");
  page_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_data |=> (addr_ptr[12:5] == $past(addr_ptr[12:5])
                   && addr_ptr[4:0] == $past(addr_ptr[4:0]) + 5'h01))
    else $error("byte counter wrong");
  wp_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (launch && wp_s) |=> (!commit && busy == $past(busy)))
    else $error("protected write started");
  write_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    launch_wr |=> (commit && busy) ##1 (!commit && busy)[*6])
    else $error("write cycle not started");
  ack_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ack_pend && scl_fall && !start_ev && !stop_ev) |=> sda_oe)
    else $error("acknowledge not driven");
  no_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (stop_ev && !data_seen) |=> !commit)
    else $error("write without data byte");
  addr_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_alo |=> (addr_ptr[7:0] == $past(rx_byte) && commit_mask == '0 && !data_seen))
    else $error("low address not loaded");
  busy_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (take_ctrl && busy) |=> (state == SEC_IGNORE && !ack_pend))
    else $error("control byte answered while busy");
  ctrl_accept_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (take_ctrl && type_ok && csel_ok && !busy && !is_read)
    |=> (state == SEC_ADDR_HI && ack_pend))
    else $error("matching write control byte refused");
  data_ack_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_data |=> (ack_pend && data_seen))
    else $error("data byte not acknowledged");
  byte_abort_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (start_ev || stop_ev) |=> (bit_cnt == 4'h0 && !sda_oe && !ack_pend))
    else $error("partial byte not discarded");
  page_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (busy && $past(busy)) |-> (!commit && $stable(commit_page)))
    else $error("write cycle target changed");
  commit_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    commit |-> ($past(start_ev || stop_ev) && $past(data_seen) && !$past(wp_s)))
    else $error("commit without a qualified launch");

endmodule : sec_client
`default_nettype wire

/* File: tb/sec_host.sv */
// Behavioural two-wire bus host driving clock, data, Start and Stop.
// Assumes a pull-up on the data wire: a released line reads high.
`timescale 1ns/1ns
`default_nettype none

module sec_host (
  // Bus wires
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Start, also usable as repeated Start
  task automatic start();
    sda_drv = 1'b1;
    #10 scl = 1'b1;
    #15 sda_drv = 1'b0;
    #15 scl = 1'b0;
  endtask : start

  // Stop, entered with the clock low
  task automatic stop();
    #5 sda_drv = 1'b0;
    #10 scl = 1'b1;
    #15 sda_drv = 1'b1;
    #30;
  endtask : stop

  // Data changes only while the clock is low
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #5 sda_drv = b[i];
      #10 scl = 1'b1;
      #15 scl = 1'b0;
    end
  endtask : bits

  // Byte plus ninth clock; extra low time lets the client let go
  task automatic send(input logic [7:0] b, output logic ack);
    bits(b, 8);
    #5 sda_drv = 1'b1;
    #10 scl = 1'b1;
    #7 ack = ~sda;
    #8 scl = 1'b0;
    #15;
  endtask : send
endmodule : sec_host

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the client write path.
// Assumes the host model drives the bus; commits are checked from a queue.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import sec_pkg::*;
  localparam logic [3:0]  TCODE = 4'h5;  // Arbitrary value
  localparam int unsigned WCYC  = 200;
  logic         clk_sys = 1'b0;
  logic         resetn  = 1'b0;
  logic         wp      = 1'b0;
  logic [2:0]   cs      = 3'h0;
  logic         scl, sda_drv, sda_out, sda_oe, busy, commit, ack;
  logic [12:0]  addr_ptr, ptr;
  logic [7:0]   commit_page;
  logic [255:0] commit_data, pg_d, mx;
  logic [31:0]  commit_mask, pg_m;
  logic [295:0] e;
  logic [295:0] exp_q[$];
  int           n_fail = 0;
  int           samples_checked = 0;
  int           bcnt = 0;
  wire logic    sda = (sda_oe ? sda_out : 1'b1) & sda_drv;

  always #2 clk_sys = ~clk_sys;

  sec_host host_u (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  sec_client #(.TYPE_CODE(TCODE), .WRITE_CYCLES(WCYC), .PAGE_BYTES(32)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .scl_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_sel_bit_low(cs[0]), .chip_sel_bit_mid(cs[1]), .chip_sel_bit_high(cs[2]),
    .wp(wp), .busy(busy), .addr_ptr(addr_ptr), .commit(commit),
    .commit_page(commit_page), .commit_data(commit_data), .commit_mask(commit_mask));

  task automatic check(input logic [295:0] got, input logic [295:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic ctrl(input logic [3:0] t, input logic [2:0] c, input logic rw,
                      input logic exp);
    host_u.start();
    host_u.send({t, c, rw}, ack);
    check(ack, exp);
  endtask : ctrl

  // Control, address high with junk top bits, address low
  task automatic hdr(input logic [12:0] a);
    ctrl(TCODE, cs, 1'b0, 1'b1);
    host_u.send({3'($urandom_range(7, 0)), a[12:8]}, ack);
    check(ack, 1'b1);
    host_u.send(a[7:0], ack);
    check(ack, 1'b1);
    check(addr_ptr, a);
    ptr = a;
    pg_m = 32'h0;
    pg_d = 256'h0;
  endtask : hdr

  task automatic dbyte(input logic [7:0] d);
    host_u.send(d, ack);
    check(ack, 1'b1);
    pg_d[ptr[4:0]*8 +: 8] = d;
    pg_m[ptr[4:0]] = 1'b1;
    ptr[4:0] = ptr[4:0] + 5'h1;
  endtask : dbyte

  // Stop, then poll until acknowledged
  task automatic endw(input logic exp, input logic nwp);
    int n;
    n = 0;
    if (exp) exp_q.push_back({ptr[12:5], pg_m, pg_d});
    host_u.stop();
    check(busy, exp);
    @(posedge clk_sys) #1 wp = nwp;
    ack = 1'b0;
    while (!ack && n < 20) begin
      host_u.start();
      host_u.send({TCODE, cs, 1'b0}, ack);
      n++;
    end
    host_u.stop();
    check(n > 1, exp);
    check(ack, 1'b1);
    if (!ack) final_report();
    check(addr_ptr, ptr);
    @(posedge clk_sys) #1 wp = 1'b0;
  endtask : endw

  // Commit monitor and busy length count
  always @(posedge clk_sys) begin
    if (commit === 1'b1) begin
      if (exp_q.size() == 0) check(296'h1, 296'h0);
      else begin
        e = exp_q.pop_front();
        for (int i = 0; i < 32; i++) mx[i*8 +: 8] = {8{e[256+i]}};
        check({commit_page, commit_mask, commit_data & mx}, e);
      end
    end
    if (busy === 1'b1) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      check(bcnt, WCYC);
      bcnt <= 0;
    end
  end

  initial begin : main
    logic [12:0] a;
    void'($urandom(32'h68b2));
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    cs = 3'($urandom_range(7, 0));
    repeat (6) @(posedge clk_sys);
    // Byte write to a random place
    hdr(13'($urandom_range(8191, 0)));
    dbyte(8'($urandom_range(255, 0)));
    endw(1'b1, 1'b0);
    // Wrong chip select bits, wrong type code, then a read
    for (int k = 0; k < 4; k++) begin
      if (k < 3) ctrl(TCODE, cs ^ (3'h1 << k), 1'b0, 1'b0);
      else ctrl(TCODE ^ 4'h8, cs, 1'b0, 1'b0);
      host_u.stop();
    end
    ctrl(TCODE, cs, 1'b1, 1'b1);
    host_u.stop();
    // 34 bytes from offset 30 wrap inside the page
    a = {8'($urandom_range(255, 0)), 5'd30};
    hdr(a);
    repeat (34) dbyte(8'($urandom_range(255, 0)));
    check(busy, 1'b0);
    endw(1'b1, 1'b0);
    // Protected write: acknowledged, nothing committed
    @(posedge clk_sys) #1 wp = 1'b1;
    hdr(13'($urandom_range(8191, 0)));
    dbyte(8'h3c);
    endw(1'b0, 1'b0);
    // Protect raised just after the Stop has no effect
    hdr(13'h1fff);
    dbyte(8'hc3);
    endw(1'b1, 1'b1);
    // Straps low; aborts in mid-byte
    @(posedge clk_sys) #1 cs = 3'h0;
    repeat (4) @(posedge clk_sys);
    hdr(13'h0123);
    host_u.bits(8'ha5, 4);
    endw(1'b0, 1'b0);
    hdr(13'h0456);
    dbyte(8'h5a);
    host_u.bits(8'hff, 3);
    endw(1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule : tb

`default_nettype wire
